// ### tcoc_consts.svh
// Register offsets, field positions and reset values of the compare-output timer.
// Assumes inclusion by bare name from the package and the design module.
`ifndef TCOC_CONSTS_SVH
`define TCOC_CONSTS_SVH

// Documented per-timer output mode control offsets
`define TCOC_T1_CTRL_A 12'h0080
`define TCOC_T3_CTRL_A 12'h0090
`define TCOC_T4_CTRL_A 12'h00a0
`define TCOC_T5_CTRL_A 12'h0120
// Offsets relative to the instance base
`define TCOC_OFS_CTRL_A 12'h0000
`define TCOC_OFS_CTRL_B 12'h0001
`define TCOC_OFS_CNT_L 12'h0004
`define TCOC_OFS_CNT_H 12'h0005
`define TCOC_OFS_TOP_L 12'h0006
`define TCOC_OFS_TOP_H 12'h0007
`define TCOC_OFS_CMP_L 12'h0008
`define TCOC_OFS_PIN_DIR 12'h000e
`define TCOC_OFS_PIN_DATA 12'h000f
`define TCOC_OFS_IRQ_STAT 12'h0010
`define TCOC_OFS_IRQ_EN 12'h0011
`define TCOC_OFS_IRQ_CLR 12'h0012
// Field positions
`define TCOC_MODE_A_HI 7
`define TCOC_MODE_B_HI 5
`define TCOC_MODE_C_HI 3
`define TCOC_WGM_LOW_HI 1
`define TCOC_WGM_HIGH_HI 4
`define TCOC_WGM_HIGH_LO 3
// Reset values
`define TCOC_CTRL_RESET 8'h00
`define TCOC_CNT_RESET 16'h0000
// Fixed TOP values and BOTTOM
`define TCOC_TOP_8BIT 16'h00ff
`define TCOC_TOP_9BIT 16'h01ff
`define TCOC_TOP_10BIT 16'h03ff
`define TCOC_MAX 16'hffff
`define TCOC_BOTTOM 16'h0000

`endif

// ### tcoc_pkg.sv
// Types shared by the compare-output timer.
// Assumes tcoc_consts.svh sits in the same folder.
`include "tcoc_consts.svh"

package tcoc_pkg;
	// Counting family, one-hot
	typedef enum logic [4:0]
	{
		TCOC_NORMAL = 5'b00001,
		TCOC_CLEAR_ON_MATCH = 5'b00010,
		TCOC_FAST = 5'b00100,
		TCOC_PHASE = 5'b01000,
		TCOC_PHASE_FREQ = 5'b10000
	} tcoc_family_t;

	// Source of TOP
	typedef enum logic [4:0]
	{
		TCOC_TOP_FIXED_MAX = 5'b00001,
		TCOC_TOP_FIXED_8 = 5'b00010,
		TCOC_TOP_FIXED_9 = 5'b00100,
		TCOC_TOP_FIXED_10 = 5'b01000,
		TCOC_TOP_CMP_A = 5'b10000
	} tcoc_top_src_t;
endpackage : tcoc_pkg

// ### tcoc_timer.sv
// Sixteen-bit timer with three compare outputs (A, B, C) and their pin control.
// Assumes a same-clock one-cycle timer tick from a prescaler and a plain register port.
//
// Strobed register access was chosen for this implementation.
`include "tcoc_consts.svh"

module tcoc_timer #(
	parameter logic [11:0] BASE = `TCOC_T1_CTRL_A,
	parameter int WIDTH = 16
) (
	input wire logic i_clk, // 50 MHz clock
	input wire logic i_rst_b, // Async reset, active low
	input wire logic i_timer_tick, // One-cycle count enable
	input wire logic [11:0] i_addr, // Register address
	input wire logic [7:0] i_wr_data, // Write data
	input wire logic i_wr, // Write strobe
	input wire logic i_rd, // Read strobe
	output logic [7:0] o_rd_data, // Read data, cycle after strobe
	output logic [2:0] o_pin_out, // Pin levels A, B, C
	output logic [2:0] o_pin_oe_b, // Pin driver enable, active low
	output logic [2:0] o_compare_out, // Raw compare outputs
	output tcoc_pkg::tcoc_family_t o_family, // Decoded counting family
	output logic o_irq // Level interrupt
);
	import tcoc_pkg::*;

	logic [7:0] ctrl_a_reg; // Output mode control
	logic [1:0] wgm_high_reg; // Upper waveform mode bits
	logic [WIDTH-1:0] cnt_reg; // Counter value
	logic [WIDTH-1:0] top_reg; // Register-defined TOP
	logic [WIDTH-1:0] cmp_buf_reg [3]; // Written compare values
	logic [WIDTH-1:0] cmp_reg [3]; // Active compare values
	logic down_reg; // Counting down in dual slope
	logic [2:0] oc_reg; // Compare output registers
	logic [2:0] dir_reg; // Pin direction bits
	logic [2:0] port_reg; // Normal port data
	logic [3:0] stat_reg; // Overflow, match A, B, C
	logic [3:0] irq_en_reg; // Interrupt enables
	logic [3:0] wgm; // Full waveform mode
	tcoc_family_t family; // Decoded family
	logic [WIDTH-1:0] top; // Current TOP
	logic at_top; // Counter equals TOP
	logic at_bottom; // Counter equals BOTTOM
	logic turn_bottom; // Dual slope leaving BOTTOM
	logic reload; // Compare buffers copied in
	logic ovf; // Overflow event this tick
	logic [2:0] match; // Compare equality per channel
	logic [2:0] hit; // Match event this tick
	logic [2:0] conn; // Channel drives its pin
	logic [2:0] oc_next; // Next compare outputs
	logic [3:0] ev; // Events into status
	logic wr_hit; // Any write this cycle
	logic [11:0] ofs; // Offset from base

	// Mode field of one channel
	function automatic logic [1:0] chan_mode(input logic [7:0] c, input int ch);
		chan_mode = c[`TCOC_MODE_A_HI-2*ch -: 2];
	endfunction : chan_mode

	// Family of a waveform mode
	function automatic tcoc_family_t family_of(input logic [3:0] m);
		case (m)
			4'h0, 4'hd: family_of = TCOC_NORMAL;
			4'h4, 4'hc: family_of = TCOC_CLEAR_ON_MATCH;
			4'h5, 4'h6, 4'h7, 4'he, 4'hf: family_of = TCOC_FAST;
			4'h8, 4'h9: family_of = TCOC_PHASE_FREQ;
			default: family_of = TCOC_PHASE;
		endcase
	endfunction : family_of

	// Where TOP comes from; fixed MAX otherwise, register TOP picked by the caller
	function automatic tcoc_top_src_t top_src_of(input logic [3:0] m);
		case (m)
			4'h1, 4'h5: top_src_of = TCOC_TOP_FIXED_8;
			4'h2, 4'h6: top_src_of = TCOC_TOP_FIXED_9;
			4'h3, 4'h7: top_src_of = TCOC_TOP_FIXED_10;
			4'h4, 4'h9, 4'hb, 4'hf: top_src_of = TCOC_TOP_CMP_A;
			default: top_src_of = TCOC_TOP_FIXED_MAX;
		endcase
	endfunction : top_src_of

	// Low mode bits from control A, high from control B
	assign wgm = {wgm_high_reg, ctrl_a_reg[`TCOC_WGM_LOW_HI:0]};
	assign family = family_of(wgm);
	assign o_family = family;
	assign ofs = i_addr - BASE;
	assign wr_hit = i_wr;

	// TOP selection; register TOP only for the modes that name it
	always_comb
	begin
		case (top_src_of(wgm))
			TCOC_TOP_FIXED_8: top = WIDTH'(`TCOC_TOP_8BIT);
			TCOC_TOP_FIXED_9: top = WIDTH'(`TCOC_TOP_9BIT);
			TCOC_TOP_FIXED_10: top = WIDTH'(`TCOC_TOP_10BIT);
			TCOC_TOP_CMP_A: top = cmp_reg[0];
			default:
			begin
				// Modes 8, 10, 12, 14 take TOP from the TOP register
				if (wgm == 4'h8 || wgm == 4'ha || wgm == 4'hc || wgm == 4'he)
					top = top_reg;
				else
					top = WIDTH'(`TCOC_MAX);
			end
		endcase
	end

	assign at_top = (cnt_reg == top);
	assign at_bottom = (cnt_reg == WIDTH'(`TCOC_BOTTOM));
	assign turn_bottom = down_reg && at_bottom;

	// Reload points: immediate outside PWM, TOP for fast and phase, BOTTOM for phase-freq
	always_comb
	begin
		case (family)
			TCOC_FAST, TCOC_PHASE: reload = i_timer_tick && at_top && !down_reg;
			TCOC_PHASE_FREQ: reload = i_timer_tick && turn_bottom;
			default: reload = 1'b1;
		endcase
	end

	// Overflow: MAX wrap, fast at TOP, dual slope at BOTTOM
	always_comb
	begin
		case (family)
			TCOC_FAST: ovf = i_timer_tick && at_top;
			TCOC_PHASE, TCOC_PHASE_FREQ: ovf = i_timer_tick && turn_bottom;
			default: ovf = i_timer_tick && (cnt_reg == WIDTH'(`TCOC_MAX));
		endcase
	end

	// Compare equality and tick-qualified match events
	always_comb
	begin
		for (int i = 0; i < 3; i++)
		begin
			match[i] = (cnt_reg == cmp_reg[i]);
			hit[i] = i_timer_tick && match[i];
		end
	end

	// Pin connection per channel
	always_comb
	begin
		for (int i = 0; i < 3; i++)
		begin
			case (chan_mode(ctrl_a_reg, i))
				2'b00: conn[i] = 1'b0;
				2'b01:
				begin
					// Toggle code connects every channel outside PWM, and only A in special PWM modes
					if (family == TCOC_FAST)
						conn[i] = (i == 0) && (wgm == 4'he || wgm == 4'hf);
					else if (family == TCOC_PHASE || family == TCOC_PHASE_FREQ)
						conn[i] = (i == 0) && (wgm == 4'h9 || wgm == 4'hb);
					else
						conn[i] = 1'b1;
				end
				default: conn[i] = 1'b1;
			endcase
		end
	end

	// Next compare output values
	always_comb
	begin
		oc_next = oc_reg;
		for (int i = 0; i < 3; i++)
		begin
			if (conn[i] && i_timer_tick)
			begin
				case (family)
					TCOC_FAST:
					begin
						if (chan_mode(ctrl_a_reg, i) == 2'b01)
						begin
							if (match[i])
								oc_next[i] = ~oc_reg[i];
						end
						else if (at_top)
							oc_next[i] = ~ctrl_a_reg[`TCOC_MODE_A_HI - 1 - 2 * i];
						else if (match[i] && cmp_reg[i] != top)
							oc_next[i] = ctrl_a_reg[`TCOC_MODE_A_HI - 1 - 2 * i];
					end
					TCOC_PHASE, TCOC_PHASE_FREQ:
					begin
						if (match[i])
						begin
							if (chan_mode(ctrl_a_reg, i) == 2'b01)
								oc_next[i] = ~oc_reg[i];
							else
								oc_next[i] = ctrl_a_reg[`TCOC_MODE_A_HI - 1 - 2 * i] ^ down_reg;
						end
					end
					default:
					begin
						if (match[i])
						begin
							if (chan_mode(ctrl_a_reg, i) == 2'b01)
								oc_next[i] = ~oc_reg[i];
							else
								oc_next[i] = ctrl_a_reg[`TCOC_MODE_A_HI - 1 - 2 * i];
						end
					end
				endcase
			end
		end
	end

	// Counter and direction, advanced only by the tick
	always_ff @(posedge i_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			cnt_reg <= WIDTH'(`TCOC_CNT_RESET);
			down_reg <= 1'b0;
		end
		else if (wr_hit && ofs == `TCOC_OFS_CNT_L)
			cnt_reg[7:0] <= i_wr_data;
		else if (wr_hit && ofs == `TCOC_OFS_CNT_H)
			cnt_reg[WIDTH-1:8] <= i_wr_data[WIDTH-9:0];
		else if (i_timer_tick)
		begin
			case (family)
				TCOC_PHASE, TCOC_PHASE_FREQ:
				begin
					// Turn around at TOP and BOTTOM
					if (!down_reg && at_top)
					begin
						down_reg <= 1'b1;
						cnt_reg <= cnt_reg - WIDTH'(1);
					end
					else if (turn_bottom)
					begin
						down_reg <= 1'b0;
						cnt_reg <= cnt_reg + WIDTH'(1);
					end
					else if (down_reg)
						cnt_reg <= cnt_reg - WIDTH'(1);
					else
						cnt_reg <= cnt_reg + WIDTH'(1);
				end
				TCOC_NORMAL:
				begin
					down_reg <= 1'b0;
					cnt_reg <= cnt_reg + WIDTH'(1);
				end
				default:
				begin
					// Single slope wraps to BOTTOM after TOP
					down_reg <= 1'b0;
					cnt_reg <= at_top ? WIDTH'(`TCOC_BOTTOM) : cnt_reg + WIDTH'(1);
				end
			endcase
		end
	end

	// Control, TOP, pin and enable registers
	always_ff @(posedge i_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			ctrl_a_reg <= `TCOC_CTRL_RESET;
			wgm_high_reg <= 2'b00;
			top_reg <= WIDTH'(`TCOC_CNT_RESET);
			dir_reg <= 3'b000;
			port_reg <= 3'b000;
			irq_en_reg <= 4'h0;
		end
		else if (wr_hit)
		begin
			case (ofs)
				`TCOC_OFS_CTRL_A: ctrl_a_reg <= i_wr_data;
				`TCOC_OFS_CTRL_B:
					wgm_high_reg <= i_wr_data[`TCOC_WGM_HIGH_HI:`TCOC_WGM_HIGH_LO];
				`TCOC_OFS_TOP_L: top_reg[7:0] <= i_wr_data;
				`TCOC_OFS_TOP_H: top_reg[WIDTH-1:8] <= i_wr_data[WIDTH-9:0];
				`TCOC_OFS_PIN_DIR: dir_reg <= i_wr_data[2:0];
				`TCOC_OFS_PIN_DATA: port_reg <= i_wr_data[2:0];
				`TCOC_OFS_IRQ_EN: irq_en_reg <= i_wr_data[3:0];
				default: ctrl_a_reg <= ctrl_a_reg;
			endcase
		end
	end

	// Compare buffers written by software, active copies at reload
	always_ff @(posedge i_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			for (int i = 0; i < 3; i++)
			begin
				cmp_buf_reg[i] <= WIDTH'(`TCOC_CNT_RESET);
				cmp_reg[i] <= WIDTH'(`TCOC_CNT_RESET);
			end
		end
		else
		begin
			for (int i = 0; i < 3; i++)
			begin
				if (wr_hit && ofs == `TCOC_OFS_CMP_L + 12'(2*i))
					cmp_buf_reg[i][7:0] <= i_wr_data;
				if (wr_hit && ofs == `TCOC_OFS_CMP_L + 12'(2*i+1))
					cmp_buf_reg[i][WIDTH-1:8] <= i_wr_data[WIDTH-9:0];
				if (reload)
					cmp_reg[i] <= cmp_buf_reg[i];
			end
		end
	end

	// Compare output registers
	always_ff @(posedge i_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
			oc_reg <= 3'b000;
		else
			oc_reg <= oc_next;
	end

	// Sticky status; a new event wins over a clear in the same cycle
	assign ev = {hit[2], hit[1], hit[0], ovf};
	always_ff @(posedge i_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
			stat_reg <= 4'h0;
		else if (wr_hit && ofs == `TCOC_OFS_IRQ_CLR)
			stat_reg <= (stat_reg & ~i_wr_data[3:0]) | ev;
		else
			stat_reg <= stat_reg | ev;
	end

	// Read data, registered one cycle after the strobe
	always_ff @(posedge i_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
			o_rd_data <= 8'h00;
		else if (i_rd)
		begin
			case (ofs)
				`TCOC_OFS_CTRL_A: o_rd_data <= ctrl_a_reg;
				`TCOC_OFS_CTRL_B: o_rd_data <= {3'b000, wgm_high_reg, 3'b000};
				`TCOC_OFS_CNT_L: o_rd_data <= cnt_reg[7:0];
				`TCOC_OFS_CNT_H: o_rd_data <= cnt_reg[WIDTH-1:8];
				`TCOC_OFS_TOP_L: o_rd_data <= top_reg[7:0];
				`TCOC_OFS_TOP_H: o_rd_data <= top_reg[WIDTH-1:8];
				`TCOC_OFS_PIN_DIR: o_rd_data <= {5'b00000, dir_reg};
				`TCOC_OFS_PIN_DATA: o_rd_data <= {5'b00000, port_reg};
				`TCOC_OFS_IRQ_STAT: o_rd_data <= {4'h0, stat_reg};
				`TCOC_OFS_IRQ_EN: o_rd_data <= {4'h0, irq_en_reg};
				12'h0008: o_rd_data <= cmp_buf_reg[0][7:0];
				12'h0009: o_rd_data <= cmp_buf_reg[0][WIDTH-1:8];
				12'h000a: o_rd_data <= cmp_buf_reg[1][7:0];
				12'h000b: o_rd_data <= cmp_buf_reg[1][WIDTH-1:8];
				12'h000c: o_rd_data <= cmp_buf_reg[2][7:0];
				12'h000d: o_rd_data <= cmp_buf_reg[2][WIDTH-1:8];
				default: o_rd_data <= 8'h00; // Unmapped and clear register
			endcase
		end
		else
			o_rd_data <= 8'h00;
	end

	// Pin mux: compare output overrides port data, driver follows direction only
	assign o_compare_out = oc_reg;
	assign o_pin_out = (conn & oc_reg) | (~conn & port_reg);
	assign o_pin_oe_b = ~dir_reg;
	assign o_irq = |(stat_reg & irq_en_reg);
endmodule : tcoc_timer

// ### tcoc_pin_model.sv
// Model of the three port pads fed by the timer's pin outputs.
// Assumes a pull-up on each pad, so a pad left undriven reads high.
module tcoc_pin_model
(
	input wire logic [2:0] i_pin_out, // Levels offered by the block
	input wire logic [2:0] i_pin_oe_b, // Driver enables, active low
	output logic [2:0] o_pad // Resolved pad levels
);
	timeunit 1ns;
	timeprecision 1ps;
	// A pad follows its driver, else floats to the pull-up
	always_comb
	begin
		for (int i = 0; i < 3; i++)
			o_pad[i] = i_pin_oe_b[i] ? 1'b1 : i_pin_out[i];
	end
endmodule : tcoc_pin_model

// ### tcoc_timer_checker.sv
// Port-level assertions for the compare-output timer.
// Assumes one clock domain; register state is shadowed from bus writes.
`include "tcoc_consts.svh"

module tcoc_timer_checker
	import tcoc_pkg::*;
#(
	parameter logic [11:0] BASE = `TCOC_T1_CTRL_A
) (
	input wire logic i_clk, // Clock
	input wire logic i_rst_b, // Reset, active low
	input wire logic i_timer_tick, // Count enable
	input wire logic [11:0] i_addr, // Address
	input wire logic [7:0] i_wr_data, // Write data
	input wire logic i_wr, // Write strobe
	input wire logic i_rd, // Read strobe
	input wire logic [7:0] o_rd_data, // Read data
	input wire logic [2:0] o_pin_out, // Pin levels
	input wire logic [2:0] o_pin_oe_b, // Driver enables
	input wire logic [2:0] o_compare_out, // Compare outputs
	input wire tcoc_pkg::tcoc_family_t o_family, // Decoded family
	input wire logic o_irq // Interrupt
);
	logic [7:0] ctrl_a_reg; // Mode fields, low waveform bits
	logic [7:0] ctrl_b_reg; // High waveform bits
	logic [2:0] data_reg; // Port data
	logic [7:0] en_reg; // Interrupt enables
	logic [2:0] wr_low; // Low write bits
	logic [3:0] wgm; // Full waveform mode
	logic nonpwm; // Normal or clear-on-match
	assign wr_low = i_wr_data[2:0];
	assign wgm = {ctrl_b_reg[`TCOC_WGM_HIGH_HI:`TCOC_WGM_HIGH_LO], ctrl_a_reg[1:0]};
	assign nonpwm = o_family == TCOC_NORMAL || o_family == TCOC_CLEAR_ON_MATCH;
	// Shadow registers; a write lands at the same edge as in the block
	always_ff @(posedge i_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			ctrl_a_reg <= 8'h00;
			ctrl_b_reg <= 8'h00;
			data_reg <= 3'h0;
			en_reg <= 8'h00;
		end
		else if (i_wr)
		begin
			if (i_addr == BASE)
				ctrl_a_reg <= i_wr_data;
			if (i_addr == BASE + `TCOC_OFS_CTRL_B)
				ctrl_b_reg <= i_wr_data;
			if (i_addr == BASE + `TCOC_OFS_PIN_DATA)
				data_reg <= wr_low;
			if (i_addr == BASE + `TCOC_OFS_IRQ_EN)
				en_reg <= i_wr_data;
		end
	end
	// Independent decode of the mode table
	function automatic tcoc_family_t fam_exp(input logic [3:0] m);
		case (m)
			4'h1, 4'h2, 4'h3, 4'ha, 4'hb: return TCOC_PHASE;
			4'h4, 4'hc: return TCOC_CLEAR_ON_MATCH;
			4'h5, 4'h6, 4'h7, 4'he, 4'hf: return TCOC_FAST;
			4'h8, 4'h9: return TCOC_PHASE_FREQ;
			default: return TCOC_NORMAL;
		endcase
	endfunction : fam_exp
	default clocking c_main @(posedge i_clk);
	endclocking
	default disable iff (!i_rst_b);
	// Write then read of the mode register
	sequence s_ctrl_write;
		i_wr && i_addr == BASE;
	endsequence
	sequence s_ctrl_read;
		i_rd && i_addr == BASE;
	endsequence
	a_read_back: assert property (s_ctrl_write ##1 s_ctrl_read
		|=> o_rd_data == $past(i_wr_data, 2))
		else $error("mode register read back wrong");
	a_read_quiet: assert property (!i_rd |=> o_rd_data == 8'h00)
		else $error("read data without strobe");
	a_family_decode: assert property (o_family == fam_exp(wgm))
		else $error("waveform family decode wrong");
	a_hold_no_tick: assert property (!i_timer_tick |=> $stable(o_compare_out))
		else $error("compare output moved without tick");
	a_dir_drives: assert property (i_wr && i_addr == BASE + `TCOC_OFS_PIN_DIR
		|=> o_pin_oe_b == ~$past(wr_low))
		else $error("driver enable not from direction");
	a_disc_port: assert property ((ctrl_a_reg[7:6] != 2'b00 || o_pin_out[0] == data_reg[0])
		&& (ctrl_a_reg[3:2] != 2'b00 || o_pin_out[2] == data_reg[2]))
		else $error("disconnected pin not port data");
	a_conn_nonpwm: assert property (nonpwm && ctrl_a_reg[5:4] != 2'b00
		|-> o_pin_out[1] == o_compare_out[1])
		else $error("connected pin not compare output");
	a_set_sticks: assert property (o_family == TCOC_NORMAL && ctrl_a_reg[3:2] == 2'b11
		&& o_compare_out[2] && !i_wr |=> o_compare_out[2])
		else $error("set mode output dropped");
	a_fast_c_off: assert property (o_family == TCOC_FAST && ctrl_a_reg[3:2] == 2'b01
		|-> o_pin_out[2] == data_reg[2])
		else $error("fast toggle code drove channel c");
	a_irq_masked: assert property (en_reg == 8'h00 && $past(en_reg) == 8'h00 |-> !o_irq)
		else $error("interrupt with no enable");
endmodule : tcoc_timer_checker

bind tcoc_timer tcoc_timer_checker #(.BASE(BASE)) u_tcoc_timer_checker (.i_clk(i_clk),
	.i_rst_b(i_rst_b), .i_timer_tick(i_timer_tick), .i_addr(i_addr), .i_wr_data(i_wr_data),
	.i_wr(i_wr), .i_rd(i_rd), .o_rd_data(o_rd_data), .o_pin_out(o_pin_out),
	.o_pin_oe_b(o_pin_oe_b), .o_compare_out(o_compare_out), .o_family(o_family), .o_irq(o_irq));

// ### tb_tcoc_timer.sv
// Self-checking bench for the compare-output timer and its pads.
// Assumes the checker binds itself; timer tick is made here by hand.
`include "tcoc_consts.svh"
`define CHK(nm, e, g) \
	begin \
		checked++; \
		if ((g) !== (e)) \
		begin \
			miscompares++; \
			$display("[ERR] %s expected %0h seen %0h", nm, e, g); \
		end \
	end

module tb_tcoc_timer;
	timeunit 1ns;
	timeprecision 1ps;
	import tcoc_pkg::*;
	localparam logic [11:0] BASE = `TCOC_T1_CTRL_A; // Timer 1 instance
	logic i_clk, i_rst_b, i_timer_tick, i_wr, i_rd; // Controls
	logic [11:0] i_addr; // Bus address
	logic [7:0] i_wr_data, o_rd_data; // Bus data
	logic [2:0] o_pin_out, o_pin_oe_b, o_compare_out, pad; // Pin side
	tcoc_family_t o_family; // Decoded family
	logic o_irq; // Interrupt
	int checked, miscompares; // Counters
	string tab = "NPPPCFFFQQPPCNFF"; // Family letter per mode
	tcoc_timer #(.BASE(BASE)) u_tcoc_timer (.i_clk(i_clk), .i_rst_b(i_rst_b),
		.i_timer_tick(i_timer_tick), .i_addr(i_addr), .i_wr_data(i_wr_data), .i_wr(i_wr),
		.i_rd(i_rd), .o_rd_data(o_rd_data), .o_pin_out(o_pin_out), .o_pin_oe_b(o_pin_oe_b),
		.o_compare_out(o_compare_out), .o_family(o_family), .o_irq(o_irq));
	tcoc_pin_model u_tcoc_pin_model (.i_pin_out(o_pin_out), .i_pin_oe_b(o_pin_oe_b), .o_pad(pad));
	// 50 MHz clock
	always #10 i_clk = ~i_clk;
	function automatic tcoc_family_t fam_of(input byte c);
		case (c)
			"C": return TCOC_CLEAR_ON_MATCH;
			"F": return TCOC_FAST;
			"P": return TCOC_PHASE;
			"Q": return TCOC_PHASE_FREQ;
			default: return TCOC_NORMAL;
		endcase
	endfunction : fam_of
	// Reset held five cycles; every scenario starts clean
	task automatic do_reset();
		i_rst_b <= 1'b0;
		i_wr <= 1'b0;
		i_rd <= 1'b0;
		i_timer_tick <= 1'b0;
		repeat (5) @(posedge i_clk);
		i_rst_b <= 1'b1;
		@(posedge i_clk);
	endtask : do_reset
	// Write strobe stays up; the next task lowers it, so writes chain
	task automatic wr(input logic [11:0] ofs, input logic [7:0] d);
		i_wr <= 1'b1;
		i_addr <= BASE + ofs;
		i_wr_data <= d;
		@(posedge i_clk);
	endtask : wr
	// Read data stand only in the cycle after the strobe
	task automatic rd_chk(input logic [11:0] ofs, input logic [7:0] e, input string nm);
		i_wr <= 1'b0;
		i_rd <= 1'b1;
		i_addr <= BASE + ofs;
		@(posedge i_clk);
		i_rd <= 1'b0;
		#1;
		`CHK(nm, e, o_rd_data)
	endtask : rd_chk
	// One-cycle tick pulses with a gap between them
	task automatic tick(input int n);
		i_wr <= 1'b0;
		repeat (n)
		begin
			i_timer_tick <= 1'b1;
			@(posedge i_clk);
			i_timer_tick <= 1'b0;
			@(posedge i_clk);
		end
		#1;
	endtask : tick
	task automatic s_regs();
		do_reset();
		rd_chk(`TCOC_OFS_CTRL_A, `TCOC_CTRL_RESET, "ctrl reset");
		`CHK("oe reset", 3'h7, o_pin_oe_b)
		wr(`TCOC_OFS_CTRL_A, 8'ha5);
		rd_chk(`TCOC_OFS_CTRL_A, 8'ha5, "ctrl rw");
		rd_chk(12'h01f, 8'h00, "unmapped");
		// Every waveform mode once
		for (int m = 0; m < 16; m++)
		begin
			wr(`TCOC_OFS_CTRL_B, 8'((m >> 2) << 3));
			wr(`TCOC_OFS_CTRL_A, 8'(m & 3));
			tick(0);
			`CHK("family", fam_of(tab[m]), o_family)
		end
	endtask : s_regs
	// Normal mode: A toggles, B clears, C sets at count 2
	task automatic s_nonpwm();
		do_reset();
		for (int i = 0; i < 3; i++)
			wr(`TCOC_OFS_CMP_L + 12'(2 * i), 8'h02);
		wr(`TCOC_OFS_PIN_DIR, 8'h07);
		wr(`TCOC_OFS_IRQ_EN, 8'h02);
		wr(`TCOC_OFS_CTRL_A, 8'h6c);
		tick(2);
		`CHK("cmp early", 3'h0, o_compare_out)
		tick(1);
		`CHK("cmp match", 3'h5, o_compare_out)
		`CHK("pin", 3'h5, o_pin_out)
		`CHK("pad", 3'h5, pad)
		`CHK("irq", 1'b1, o_irq)
		rd_chk(`TCOC_OFS_IRQ_STAT, 8'h0e, "status");
		wr(`TCOC_OFS_IRQ_CLR, 8'h02);
		// One tick with no match: flag stays cleared, outputs hold
		tick(1);
		`CHK("irq clr", 1'b0, o_irq)
		`CHK("cmp hold", 3'h5, o_compare_out)
		wr(`TCOC_OFS_CTRL_A, 8'h00);
		wr(`TCOC_OFS_PIN_DATA, 8'h02);
		wr(`TCOC_OFS_PIN_DIR, 8'h00);
		tick(0);
		`CHK("pin port", 3'h2, o_pin_out)
		`CHK("pad float", 3'h7, pad)
	endtask : s_nonpwm
	// Mode 14, TOP 4: A toggles, B inverting, C code 01 off
	task automatic s_fast();
		do_reset();
		wr(`TCOC_OFS_CMP_L, 8'h01);
		wr(`TCOC_OFS_CMP_L + 12'h002, 8'h02);
		wr(`TCOC_OFS_TOP_L, 8'h04);
		wr(`TCOC_OFS_PIN_DATA, 8'h04);
		wr(`TCOC_OFS_PIN_DIR, 8'h07);
		wr(`TCOC_OFS_CTRL_B, 8'h18);
		wr(`TCOC_OFS_CTRL_A, 8'h76);
		tick(3);
		`CHK("fast match", 2'h3, o_compare_out[1:0])
		tick(2);
		`CHK("fast bottom", 2'h1, o_compare_out[1:0])
		tick(2);
		`CHK("fast toggle", 2'h0, o_compare_out[1:0])
		`CHK("fast c port", 1'b1, o_pin_out[2])
	endtask : s_fast
	// Mode 10, TOP 3: B sets going up, clears coming down
	task automatic s_dual();
		do_reset();
		wr(`TCOC_OFS_CMP_L, 8'h01);
		wr(`TCOC_OFS_CMP_L + 12'h002, 8'h01);
		wr(`TCOC_OFS_TOP_L, 8'h03);
		wr(`TCOC_OFS_PIN_DATA, 8'h01);
		wr(`TCOC_OFS_PIN_DIR, 8'h07);
		wr(`TCOC_OFS_CTRL_B, 8'h10);
		wr(`TCOC_OFS_CTRL_A, 8'h72);
		tick(2);
		`CHK("up match", 1'b1, o_compare_out[1])
		tick(3);
		`CHK("past top", 1'b1, o_compare_out[1])
		tick(1);
		`CHK("down match", 1'b0, o_compare_out[1])
		`CHK("dual a port", 1'b1, o_pin_out[0])
	endtask : s_dual
	// Mode 9, TOP from compare A: A toggles, B non-inverting, new B only after BOTTOM
	task automatic s_pfc();
		do_reset();
		wr(`TCOC_OFS_CMP_L, 8'h03);
		wr(`TCOC_OFS_CMP_L + 12'h002, 8'h01);
		wr(`TCOC_OFS_PIN_DIR, 8'h07);
		wr(`TCOC_OFS_IRQ_EN, 8'h01);
		wr(`TCOC_OFS_CTRL_B, 8'h10);
		wr(`TCOC_OFS_CTRL_A, 8'h61);
		tick(2);
		// Buffered only; an early copy would show as a match at count 2
		wr(`TCOC_OFS_CMP_L + 12'h002, 8'h02);
		tick(3);
		`CHK("pfc top", 2'h1, o_compare_out[1:0])
		tick(1);
		`CHK("pfc down", 2'h3, o_compare_out[1:0])
		`CHK("pfc no ovf", 1'b0, o_irq)
		tick(1);
		`CHK("pfc ovf", 1'b1, o_irq)
		tick(1);
		`CHK("pfc reload", 2'h3, o_pin_out[1:0])
		tick(1);
		`CHK("pfc up clear", 2'h1, o_compare_out[1:0])
	endtask : s_pfc
	// Mode 15, TOP from compare A: A toggles, B at TOP stays high, C non-inverting
	task automatic s_top();
		do_reset();
		wr(`TCOC_OFS_CMP_L, 8'h02);
		wr(`TCOC_OFS_CMP_L + 12'h002, 8'h02);
		wr(`TCOC_OFS_CMP_L + 12'h004, 8'h01);
		wr(`TCOC_OFS_PIN_DIR, 8'h07);
		wr(`TCOC_OFS_CTRL_B, 8'h18);
		wr(`TCOC_OFS_CTRL_A, 8'h6b);
		tick(3);
		`CHK("top wrap", 3'h7, o_compare_out)
		tick(2);
		`CHK("top clear c", 3'h3, o_compare_out)
		tick(1);
		`CHK("top pads", 3'h6, pad)
	endtask : s_top
	task automatic tally_and_finish();
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : tally_and_finish
	// Main sequence
	initial
	begin
		i_clk = 1'b0;
		i_rst_b = 1'b0;
		i_timer_tick = 1'b0;
		i_wr = 1'b0;
		i_rd = 1'b0;
		i_addr = 12'h000;
		i_wr_data = 8'h00;
		checked = 0;
		miscompares = 0;
		#5;
		s_regs();
		s_nonpwm();
		s_fast();
		s_dual();
		s_pfc();
		s_top();
		tally_and_finish();
	end
endmodule : tb_tcoc_timer
